// ### shared/upwsc_defs.vh
// constants for the usb power, wake and send-now control block
`ifndef UPWSC_DEFS_VH
`define UPWSC_DEFS_VH
`define UPWSC_NUM_CHAN       2
`define UPWSC_RST_OUT_NS     1000
`define UPWSC_CLK_PERIOD_NS  4
`define UPWSC_RST_OUT_CYC    ((`UPWSC_RST_OUT_NS + `UPWSC_CLK_PERIOD_NS - 1) / `UPWSC_CLK_PERIOD_NS)
`define UPWSC_SETTLE_US      100
`define UPWSC_SETTLE_CYC     ((`UPWSC_SETTLE_US * 1000) / `UPWSC_CLK_PERIOD_NS)
`define UPWSC_ST_RESET       2'h0
`define UPWSC_ST_WAIT_CLK    2'h1
`define UPWSC_ST_ENUM_OK     2'h2
`endif

// ### design/upwsc_strobe_sync.v
// one channel strobe synchroniser with falling edge detector
`timescale 1ns/1ns
module upwsc_strobe_sync (
  input  wire clk_sys,
  input  wire reset_n,
  input  wire strobe_n,
  output reg  fall_pulse
);
  reg meta;   // first stage, read only by stage two
  reg sync;   // second stage
  reg last;   // previous synchronised level

  // two-flop sync, then one pulse per falling edge
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      meta       <= 1'b1;
      sync       <= 1'b1;
      last       <= 1'b1;
      fall_pulse <= 1'b0;
    end else begin
      meta       <= strobe_n;
      sync       <= meta;
      last       <= sync;
      fall_pulse <= last & ~sync;
    end
  end
endmodule

// ### design/upwsc_top.v
// usb power enable, wake and send-now control with reset handling
`timescale 1ns/1ns
`include "upwsc_defs.vh"
module upwsc_top #(
  parameter NUM_CHAN   = `UPWSC_NUM_CHAN,
  parameter SETTLE_CYC = `UPWSC_SETTLE_CYC,
  parameter RST_CYC    = `UPWSC_RST_OUT_CYC
) (
  input  wire                clk_sys,
  input  wire                reset_n,
  input  wire                ext_reset_n,
  input  wire                clock_settle_guard,
  input  wire                usb_configured,
  input  wire                usb_suspended,
  input  wire                cfg_pulldown_en,
  input  wire                cfg_remote_wake_en,
  input  wire                cfg_iso_en,
  input  wire [NUM_CHAN-1:0] send_now_wake_n,
  output reg                 power_switch_enable_n,
  output reg                 io_pulldown_en,
  output reg                 enum_enable,
  output reg                 resume_request,
  output reg  [NUM_CHAN-1:0] flush_request,
  output reg                 xfer_iso,
  output reg                 chip_reset_out_n
);
  // state codes
  localparam [1:0] ST_RESET    = `UPWSC_ST_RESET;
  localparam [1:0] ST_WAIT_CLK = `UPWSC_ST_WAIT_CLK;
  localparam [1:0] ST_ENUM_OK  = `UPWSC_ST_ENUM_OK;

  reg [1:0]            state;        // sequencer state
  reg [1:0]            next_state;   // next sequencer state
  reg [31:0]           settle_cnt;   // stable-clock count
  reg [31:0]           rst_cnt;      // reset-out stretch count
  reg [2:0]            pin_sync;     // ext reset, guard, suspend sync
  reg [2:0]            pin_meta;     // first stages, read by pin_sync only
  wire [NUM_CHAN-1:0]  strobe_fall;  // one pulse per low strobe
  wire                 ext_rst;      // synchronised external reset
  wire                 guard_ok;     // synchronised clock guard
  wire                 susp;         // synchronised suspend

  assign ext_rst  = ~pin_sync[0];
  assign guard_ok = pin_sync[1];
  assign susp     = pin_sync[2];

  // per-channel strobe synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_chan
      upwsc_strobe_sync u_sync (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .strobe_n   (send_now_wake_n[gi]),
        .fall_pulse (strobe_fall[gi])
      );
    end
  endgenerate

  // two-flop sync of outside pins
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      pin_meta <= 3'h1;
      pin_sync <= 3'h1;
    end else begin
      pin_meta <= {usb_suspended, clock_settle_guard, ext_reset_n};
      pin_sync <= pin_meta;
    end
  end

  // sequencer next state
  always @* begin
    next_state = state;
    case (state)
      ST_RESET:    next_state = ST_WAIT_CLK;
      ST_WAIT_CLK: if (settle_cnt >= SETTLE_CYC) next_state = ST_ENUM_OK;
      ST_ENUM_OK:  if (!guard_ok) next_state = ST_WAIT_CLK;
      default:     next_state = ST_RESET;
    endcase
  end

  // sequencer, counters and outputs
  always @(posedge clk_sys) begin
    if (!reset_n || ext_rst) begin
      state                 <= ST_RESET;
      settle_cnt            <= 32'h0000_0000;
      rst_cnt               <= 32'h0000_0000;
      chip_reset_out_n      <= 1'b0;
      power_switch_enable_n <= 1'b1;
      io_pulldown_en        <= 1'b0;
      enum_enable           <= 1'b0;
      resume_request        <= 1'b0;
      flush_request         <= {NUM_CHAN{1'b0}};
      xfer_iso              <= 1'b0;
    end else begin
      state <= next_state;
      // clock must stay stable for the full settle span
      if (!guard_ok)
        settle_cnt <= 32'h0000_0000;
      else if (settle_cnt < SETTLE_CYC)
        settle_cnt <= settle_cnt + 32'h0000_0001;
      // stretched reset output after power-on or external reset
      if (rst_cnt < RST_CYC)
        rst_cnt <= rst_cnt + 32'h0000_0001;
      chip_reset_out_n <= (rst_cnt >= RST_CYC);
      enum_enable <= (state == ST_ENUM_OK);
      // on once enumerated, off in suspend
      power_switch_enable_n <= ~(usb_configured & ~susp & (state == ST_ENUM_OK));
      // pull-down while power enable is inactive, one cycle behind it
      io_pulldown_en <= cfg_pulldown_en & power_switch_enable_n;
      xfer_iso <= cfg_iso_en;
      // wake in suspend, flush otherwise
      resume_request <= susp & cfg_remote_wake_en & (|strobe_fall);
      flush_request  <= susp ? {NUM_CHAN{1'b0}} : strobe_fall;
    end
  end
endmodule

// ### sim/upwsc_asserts.sv
// checker on the top ports of the power, wake and send-now block
`timescale 1ns/1ns
module upwsc_asserts #(parameter NUM_CHAN = 2, parameter RST_CYC = 4) (
  input wire                clk_sys, reset_n, ext_reset_n, clock_settle_guard,
  input wire                usb_suspended, cfg_pulldown_en, cfg_remote_wake_en,
  input wire                power_switch_enable_n, io_pulldown_en, enum_enable,
  input wire                resume_request, chip_reset_out_n,
  input wire [NUM_CHAN-1:0] send_now_wake_n, flush_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  pwr_off_susp_a: assert property (usb_suspended[*5] |-> power_switch_enable_n)
    else $error("power on in suspend");
  pull_cfg_a: assert property (io_pulldown_en |-> $past(cfg_pulldown_en))
    else $error("pulldown without cfg");
  resume_cfg_a: assert property (resume_request |-> $past(cfg_remote_wake_en))
    else $error("resume without wake cfg");
  flush_cause_a: assert property (flush_request[0] |-> !$past(send_now_wake_n[0], 3))
    else $error("flush without strobe");
  ext_rst_a: assert property (!ext_reset_n[*6] |-> !chip_reset_out_n)
    else $error("reset out high in ext reset");
  rst_hold_a: assert property ($rose(chip_reset_out_n) |-> $past(reset_n, RST_CYC))
    else $error("reset out released early");
  guard_a: assert property (!clock_settle_guard[*5] |-> !enum_enable)
    else $error("enum without stable clock");
  flush_once_a: assert property (flush_request[0] |=> !flush_request[0])
    else $error("flush held");
endmodule
bind upwsc_top upwsc_asserts #(.NUM_CHAN(NUM_CHAN), .RST_CYC(RST_CYC)) upwsc_asserts_inst (.*);

// ### sim/upwsc_host.sv
// host side model: configures once allowed, suspends on request
`timescale 1ns/1ns
module upwsc_host (
  input  wire clk_sys,
  input  wire enum_enable,
  input  wire go_suspend,
  output reg  usb_configured,
  output reg  usb_suspended
);
  initial usb_configured = 1'b0;
  initial usb_suspended = 1'b0;
  // configure only while enumeration allowed
  always @(posedge clk_sys) begin
    usb_configured <= #1 enum_enable;
    usb_suspended  <= #1 go_suspend;
  end
endmodule

// ### sim/upwsc_top_tb.sv
// bench for the power, wake and send-now block
`timescale 1ns/1ns
module upwsc_top_tb;
  reg clk_sys, reset_n, ext_reset_n, clock_settle_guard, go_suspend;
  reg cfg_pulldown_en, cfg_remote_wake_en, cfg_iso_en;
  reg [1:0] send_now_wake_n;
  wire power_switch_enable_n, io_pulldown_en, enum_enable, resume_request;
  wire xfer_iso, chip_reset_out_n, usb_configured, usb_suspended;
  wire [1:0] flush_request;
  integer failures, compares, i, nr, nf0, nf1;
  reg [4:0] rows [0:3]; // channel, suspend, wake cfg, flush, resume
  upwsc_top #(.NUM_CHAN(2), .SETTLE_CYC(8), .RST_CYC(4)) upwsc_top_inst (.*);
  upwsc_host upwsc_host_inst (.*);
  initial begin clk_sys = 0; forever #2 clk_sys = ~clk_sys; end
  // pulse counters
  always @(posedge clk_sys) begin
    nr = nr + resume_request; nf0 = nf0 + flush_request[0]; nf1 = nf1 + flush_request[1];
  end
  task step(input integer n); begin repeat (n) @(posedge clk_sys); #1; end endtask
  task chk(input [7:0] seen, input [7:0] exp, input [47:0] nm); begin
    compares = compares + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("MISMATCH %0s exp %0h seen %0h", nm, exp, seen);
    end
  end endtask
  task end_sim; begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  end endtask
  task pwr_wait; begin
    for (i = 0; i < 100 && power_switch_enable_n; i = i + 1) step(1);
    chk(power_switch_enable_n, 8'h00, "pwr");
    // bound used up: mismatch already counted, go straight to the report
    if (power_switch_enable_n !== 1'b0) end_sim;
  end endtask
  initial begin
    failures = 0; compares = 0; reset_n = 0; ext_reset_n = 1; clock_settle_guard = 1;
    cfg_pulldown_en = 1; cfg_remote_wake_en = 1; cfg_iso_en = 1; go_suspend = 0;
    send_now_wake_n = 2'h3; rows[0] = 5'h06; rows[1] = 5'h12; rows[2] = 5'h0d; rows[3] = 5'h18;
    step(3);
    reset_n = 1;
    chk(chip_reset_out_n, 8'h00, "chip_reset_out_n");
    pwr_wait;
    chk(xfer_iso, 8'h01, "iso");
    for (i = 0; i < 4; i = i + 1) begin
      go_suspend = rows[i][3]; cfg_remote_wake_en = rows[i][2]; step(8);
      chk(power_switch_enable_n, rows[i][3], "pwr");
      chk(io_pulldown_en, rows[i][3], "pd");
      nr = 0; nf0 = 0; nf1 = 0; send_now_wake_n[rows[i][4]] = 1'b0; step(6);
      send_now_wake_n = 2'h3; step(6);
      chk(rows[i][4] ? nf1 : nf0, rows[i][1], "flush");
      chk(nr, rows[i][0], "resume");
      $display("row %0d done", i);
    end
    go_suspend = 0; cfg_iso_en = 0; clock_settle_guard = 0; step(10);
    chk(xfer_iso, 8'h00, "iso");
    chk(enum_enable, 8'h00, "enum");
    chk(power_switch_enable_n, 8'h01, "pwr");
    clock_settle_guard = 1; pwr_wait;
    ext_reset_n = 0; step(8);
    chk(chip_reset_out_n, 8'h00, "chip_reset_out_n");
    ext_reset_n = 1;
    for (i = 0; i < 100 && !chip_reset_out_n; i = i + 1) step(1);
    chk(chip_reset_out_n, 8'h01, "chip_reset_out_n");
    $display("reset tests done");
    end_sim;
  end
endmodule
